/* inc/pwm_group_pkg.sv */
// Register map, field layout and reset values of the PWM group
package pwm_group_pkg;
    localparam int NCH = 3;
    localparam int CH_M = 0;
    localparam int CH_A = 1;
    localparam int CH_B = 2;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int PW = 4;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [AW-1:0] OFS_UNIT = 8'h00;
    localparam logic [AW-1:0] OFS_PRESCALE = 8'h04;
    localparam logic [AW-1:0] OFS_MODE0 = 8'h08;
    localparam logic [AW-1:0] OFS_MODE1 = 8'h0c;
    localparam logic [AW-1:0] OFS_MODE2 = 8'h10;
    localparam logic [AW-1:0] OFS_PERIOD = 8'h14;
    localparam logic [AW-1:0] OFS_DUTY_A = 8'h18;
    localparam logic [AW-1:0] OFS_DUTY_B = 8'h1c;
    localparam logic [AW-1:0] OFS_CNT_M = 8'h20;
    localparam logic [AW-1:0] OFS_CNT_A = 8'h24;
    localparam logic [AW-1:0] OFS_CNT_B = 8'h28;
    localparam logic [AW-1:0] OFS_START = 8'h2c;
    localparam logic [AW-1:0] OFS_STOP = 8'h30;
    localparam logic [AW-1:0] OFS_ENABLE = 8'h34;
    localparam logic [AW-1:0] OFS_OUT_VAL = 8'h38;
    localparam logic [AW-1:0] OFS_OUT_EN = 8'h3c;
    localparam logic [AW-1:0] OFS_OUT_LVL = 8'h40;
    localparam logic [AW-1:0] OFS_OUT_MODE = 8'h44;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Fields of channel_mode_config and prescale_select
    localparam int MODE_START_IRQ = 0;
    localparam int MODE_OP_LO = 1;
    localparam int MODE_EDGE_LO = 6;
    localparam int MODE_TRIG_LO = 8;
    localparam int MODE_MASTER = 11;
    localparam int MODE_CCS = 12;
    localparam int MODE_CKS_LO = 14;
    localparam logic [1:0] CKS_CLK_A = 2'h0;
    localparam logic [1:0] CKS_CLK_B = 2'h2;
    localparam logic [2:0] OP_INTERVAL = 3'h0;
    localparam int PRE_B_LO = 4;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DW-1:0] RST_MODE = 16'h0000;
    localparam logic [DW-1:0] RST_DATA = 16'h0000;
    localparam logic [DW-1:0] RST_COUNT = 16'hffff;
    localparam logic [7:0] RST_PRESCALE = 8'h00;

    typedef enum {SL_IDLE, SL_LOADED, SL_RUN} slave_state_t;
endpackage

/* inc/chan_if.sv */
// Control and status carrier between the group top and one channel counter
`timescale 1ns/100ps
`default_nettype none
interface chan_if;
    import pwm_group_pkg::*;
    logic tick;
    logic run;
    logic start;
    logic trig;
    logic start_irq;
    logic [DW-1:0] data;
    logic [DW-1:0] count;
    logic irq;
    logic pend;
    logic act_set;
    logic act_clr;
    modport ctrl (output tick, run, start, trig, start_irq, data,
                  input count, irq, pend, act_set, act_clr);
    modport cnt (input tick, run, start, trig, start_irq, data,
                 output count, irq, pend, act_set, act_clr);
endinterface
`default_nettype wire

/* src/clock_prescaler.sv */
// Divider that makes the two prescaled count-clock enables
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler
    import pwm_group_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic unit_en,
    input wire logic [PW-1:0] sel_a,
    input wire logic [PW-1:0] sel_b,
    output logic tick_a,
    output logic tick_b
);
    logic [15:0] div;

    function automatic logic hit(input logic [15:0] d, input logic [PW-1:0] s);
        logic [15:0] mask;
        mask = (16'h0001 << s) - 16'h0001;
        return (d & mask) == mask;
    endfunction

    always_ff @(posedge clk) begin
        if (rst || !unit_en) begin
            div <= 16'h0000;
        end else begin
            div <= div + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !unit_en) begin
            tick_a <= 1'b0;
            tick_b <= 1'b0;
        end else begin
            tick_a <= hit(div, sel_a);
            tick_b <= hit(div, sel_b);
        end
    end
endmodule // clock_prescaler
`default_nettype wire

/* src/chan_counter.sv */
// One down counter: interval mode for the master, one-count mode for a slave
`timescale 1ns/100ps
`default_nettype none
module chan_counter
    import pwm_group_pkg::*;
#(
    parameter bit IS_MASTER = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic unit_en,
    chan_if.cnt ch
);
    slave_state_t state;

    always_ff @(posedge clk) begin
        if (rst || !unit_en) begin
            ch.count <= RST_COUNT;
            ch.pend <= 1'b0;
            ch.irq <= 1'b0;
            ch.act_set <= 1'b0;
            ch.act_clr <= 1'b0;
            state <= SL_IDLE;
        end else begin
            ch.irq <= 1'b0;
            ch.act_set <= 1'b0;
            ch.act_clr <= 1'b0;
            if (IS_MASTER) begin
                if (ch.start) begin
                    ch.pend <= 1'b1;
                end else if (ch.run && ch.tick) begin
                    if (ch.pend) begin
                        ch.count <= ch.data;
                        ch.pend <= 1'b0;
                        ch.irq <= ch.start_irq;
                    end else if (ch.count == 16'h0000) begin
                        ch.count <= ch.data;
                        ch.irq <= 1'b1;
                    end else begin
                        ch.count <= ch.count - 16'h0001;
                    end
                end
            end else begin
                if (ch.start) begin
                    state <= SL_IDLE;
                end else if (ch.run && ch.trig) begin
                    ch.count <= ch.data;
                    state <= SL_LOADED;
                end else if (ch.run && ch.tick) begin
                    case (state)
                        SL_LOADED: begin
                            if (ch.count == 16'h0000) begin
                                ch.act_clr <= 1'b1;
                                ch.irq <= 1'b1;
                                state <= SL_IDLE;
                            end else begin
                                ch.act_set <= 1'b1;
                                ch.count <= ch.count - 16'h0001;
                                state <= SL_RUN;
                            end
                        end
                        SL_RUN: begin
                            if (ch.count == 16'h0000) begin
                                ch.act_clr <= 1'b1;
                                ch.irq <= 1'b1;
                                state <= SL_IDLE;
                            end else begin
                                ch.count <= ch.count - 16'h0001;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end
endmodule // chan_counter
`default_nettype wire

/* src/pwm_group.sv */
// Master and two slave channels producing two PWM outputs
//
// Operation
// - Each slave loads its duty data into its counter on every master interrupt.
// - Master counts down; at zero raises interrupt, reloads period, keeps counting.
// - Slave output goes active one count clock after the master interrupt.
// - Slave output goes inactive when its counter reaches zero; counter then stops.
// - With the start-interrupt bit set, master interrupts when counting starts.
// - Clock field 00 picks prescaled clock A, 10 picks B; count select 0.
// - Master designation bit is settable on channel 2, fixed 0 on channel 0.
// - One write starts all three; enable bits set, trigger bits self-clear.
// - Stop clears all enables; counters freeze, outputs hold their level.
// - All count registers are readable at any time; capture status unused.
// - Enabling a slave output does not change the pin while stopped.
// - Writes other than to the unit register are ignored while the unit clock enable is 0.
// - Clearing the unit clock enable resets the timer and returns pins to port mode.
// - A slave that reached zero stays stopped until the next master interrupt.
// - Period is master value plus one; duty is slave value over that.
// - A duty value beyond the period keeps the slave output continuously active.
`timescale 1ns/100ps
`default_nettype none
module pwm_group
    import pwm_group_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR_STROBE,
    input wire logic RD_STROBE,
    output logic [DW-1:0] RDATA,
    output logic PWM_OUT_A,
    output logic PWM_OUT_B,
    output logic MASTER_OUT,
    output logic TIMER_PIN_MODE,
    output logic PERIOD_IRQ,
    output logic DUTY_IRQ_A,
    output logic DUTY_IRQ_B
);
    logic unit_clock_enable;
    logic [7:0] prescale_select;
    logic [DW-1:0] channel_mode_config [NCH];
    logic [DW-1:0] chan_data [NCH];
    logic [NCH-1:0] channel_enable_status;
    logic [NCH-1:0] start_pulse;
    logic [NCH-1:0] output_value_bits;
    logic [NCH-1:0] output_enable_bits;
    logic [NCH-1:0] output_level_bits;
    logic [NCH-1:0] output_mode_bits;
    logic [NCH-1:0] act_set;
    logic [NCH-1:0] act_clr;
    logic [NCH-1:0] irq;
    logic [DW-1:0] count_val [NCH];
    logic prescaled_clock_a;
    logic prescaled_clock_b;
    logic wr;
    logic master_pend;

    chan_if chan [NCH] ();

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Unit clock enable and register writes
    assign wr = WR_STROBE && unit_clock_enable;

    always_ff @(posedge CLK) begin
        if (RST) begin
            unit_clock_enable <= 1'b0;
        end else if (WR_STROBE && ADDR == OFS_UNIT) begin
            unit_clock_enable <= WDATA[0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || !unit_clock_enable) begin
            prescale_select <= RST_PRESCALE;
            for (int i = 0; i < NCH; i++) begin
                channel_mode_config[i] <= RST_MODE;
                chan_data[i] <= RST_DATA;
            end
        end else if (wr) begin
            case (ADDR)
                OFS_PRESCALE: prescale_select <= WDATA[7:0];
                OFS_MODE0: begin
                    channel_mode_config[CH_M] <= WDATA;
                    channel_mode_config[CH_M][MODE_MASTER] <= 1'b0;
                end
                OFS_MODE1: channel_mode_config[CH_A] <= WDATA;
                OFS_MODE2: channel_mode_config[CH_B] <= WDATA;
                OFS_PERIOD: chan_data[CH_M] <= WDATA;
                OFS_DUTY_A: chan_data[CH_A] <= WDATA;
                OFS_DUTY_B: chan_data[CH_B] <= WDATA;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Start and stop triggers
    always_ff @(posedge CLK) begin
        if (RST || !unit_clock_enable) begin
            channel_enable_status <= '0;
            start_pulse <= '0;
        end else begin
            start_pulse <= '0;
            if (wr && ADDR == OFS_START) begin
                channel_enable_status <= channel_enable_status | WDATA[NCH-1:0];
                start_pulse <= WDATA[NCH-1:0];
            end else if (wr && ADDR == OFS_STOP) begin
                channel_enable_status <= channel_enable_status & ~WDATA[NCH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Output control bits and pin levels
    always_ff @(posedge CLK) begin
        if (RST || !unit_clock_enable) begin
            output_value_bits <= '0;
            output_enable_bits <= '0;
            output_level_bits <= '0;
            output_mode_bits <= '0;
        end else begin
            if (wr && ADDR == OFS_OUT_EN) output_enable_bits <= WDATA[NCH-1:0];
            if (wr && ADDR == OFS_OUT_LVL) output_level_bits <= WDATA[NCH-1:0];
            if (wr && ADDR == OFS_OUT_MODE) output_mode_bits <= WDATA[NCH-1:0];
            for (int i = 0; i < NCH; i++) begin
                if (wr && ADDR == OFS_OUT_VAL && !output_enable_bits[i]) begin
                    output_value_bits[i] <= WDATA[i];
                end else if (channel_enable_status[i] && output_enable_bits[i]
                             && output_mode_bits[i]) begin
                    if (act_set[i]) output_value_bits[i] <= 1'b1;
                    else if (act_clr[i]) output_value_bits[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PWM_OUT_A <= 1'b0;
            PWM_OUT_B <= 1'b0;
            MASTER_OUT <= 1'b0;
            TIMER_PIN_MODE <= 1'b0;
            PERIOD_IRQ <= 1'b0;
            DUTY_IRQ_A <= 1'b0;
            DUTY_IRQ_B <= 1'b0;
        end else begin
            PWM_OUT_A <= output_value_bits[CH_A] ^ (output_level_bits[CH_A] & output_mode_bits[CH_A]);
            PWM_OUT_B <= output_value_bits[CH_B] ^ (output_level_bits[CH_B] & output_mode_bits[CH_B]);
            MASTER_OUT <= output_value_bits[CH_M];
            TIMER_PIN_MODE <= unit_clock_enable;
            PERIOD_IRQ <= irq[CH_M];
            DUTY_IRQ_A <= irq[CH_A];
            DUTY_IRQ_B <= irq[CH_B];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= '0;
        end else if (RD_STROBE) begin
            case (ADDR)
                OFS_UNIT: RDATA <= {15'h0000, unit_clock_enable};
                OFS_PRESCALE: RDATA <= {8'h00, prescale_select};
                OFS_MODE0: RDATA <= channel_mode_config[CH_M];
                OFS_MODE1: RDATA <= channel_mode_config[CH_A];
                OFS_MODE2: RDATA <= channel_mode_config[CH_B];
                OFS_PERIOD: RDATA <= chan_data[CH_M];
                OFS_DUTY_A: RDATA <= chan_data[CH_A];
                OFS_DUTY_B: RDATA <= chan_data[CH_B];
                OFS_CNT_M: RDATA <= count_val[CH_M];
                OFS_CNT_A: RDATA <= count_val[CH_A];
                OFS_CNT_B: RDATA <= count_val[CH_B];
                OFS_ENABLE: RDATA <= {13'h0000, channel_enable_status};
                OFS_OUT_VAL: RDATA <= {13'h0000, output_value_bits};
                OFS_OUT_EN: RDATA <= {13'h0000, output_enable_bits};
                OFS_OUT_LVL: RDATA <= {13'h0000, output_level_bits};
                OFS_OUT_MODE: RDATA <= {13'h0000, output_mode_bits};
                default: RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Prescaler and channel counters
    clock_prescaler u_pre (
        .clk(CLK),
        .rst(RST),
        .unit_en(unit_clock_enable),
        .sel_a(prescale_select[PW-1:0]),
        .sel_b(prescale_select[PRE_B_LO +: PW]),
        .tick_a(prescaled_clock_a),
        .tick_b(prescaled_clock_b)
    );

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [1:0] cks;
        assign cks = channel_mode_config[i][MODE_CKS_LO +: 2];
        assign chan[i].tick = !channel_mode_config[i][MODE_CCS]
            && ((cks == CKS_CLK_B) ? prescaled_clock_b
                : (cks == CKS_CLK_A) ? prescaled_clock_a : 1'b0);
        assign chan[i].run = channel_enable_status[i];
        assign chan[i].start = start_pulse[i];
        assign chan[i].trig = (i != CH_M) && irq[CH_M];
        assign chan[i].start_irq = channel_mode_config[i][MODE_START_IRQ];
        assign chan[i].data = chan_data[i];
        assign count_val[i] = chan[i].count;
        assign irq[i] = chan[i].irq;
        assign act_set[i] = chan[i].act_set;
        assign act_clr[i] = chan[i].act_clr;
        chan_counter #(.IS_MASTER(i == CH_M)) u_cnt (
            .clk(CLK),
            .rst(RST),
            .unit_en(unit_clock_enable),
            .ch(chan[i])
        );
    end
    assign master_pend = chan[CH_M].pend;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic seen_trig_a;
    always_ff @(posedge CLK) begin
        if (RST || irq[CH_M]) seen_trig_a <= !RST;
        else if (chan[CH_A].tick) seen_trig_a <= 1'b0;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_slave_load: assert property (irq[CH_M] && channel_enable_status[CH_A] && !start_pulse[CH_A]
        |=> count_val[CH_A] == $past(chan_data[CH_A])) else $error("slave did not load duty");
    chk_master_reload: assert property (channel_enable_status[CH_M] && chan[CH_M].tick
        && !master_pend && !start_pulse[CH_M] && count_val[CH_M] == 16'h0000
        |=> irq[CH_M] && count_val[CH_M] == $past(chan_data[CH_M])) else $error("no reload");
    chk_active_after: assert property (act_set[CH_A] |-> $past(seen_trig_a)
        && $past(chan[CH_A].tick)) else $error("active not one tick after trigger");
    chk_inactive_zero: assert property (act_clr[CH_A] |-> count_val[CH_A] == 16'h0000)
        else $error("inactive with nonzero count");
    chk_stay_stopped: assert property (irq[CH_A] && !irq[CH_M] && !start_pulse[CH_A]
        |=> count_val[CH_A] == 16'h0000) else $error("slave restarted early");
    chk_start_irq: assert property (master_pend && chan[CH_M].tick && channel_enable_status[CH_M]
        && !start_pulse[CH_M] && channel_mode_config[CH_M][MODE_START_IRQ]
        |=> irq[CH_M]) else $error("no interrupt at start");
    chk_trigger_start: assert property (wr && ADDR == OFS_START && WDATA[2:0] == 3'h7
        |=> channel_enable_status == 3'h7 ##1 start_pulse == 3'h0) else $error("bad start");
    chk_stop_freeze: assert property (unit_clock_enable && !channel_enable_status[CH_M]
        && !start_pulse[CH_M] |=> $stable(count_val[CH_M])) else $error("counter moved");
    chk_unit_reset: assert property (!unit_clock_enable ##1 !unit_clock_enable
        |-> chan_data[CH_M] == RST_DATA && channel_enable_status == 3'h0
        && output_value_bits == 3'h0) else $error("unit reset incomplete");
    chk_master_bit0: assert property (channel_mode_config[CH_M][MODE_MASTER] == 1'b0)
        else $error("master bit set on channel 0");
    chk_count_read: assert property (RD_STROBE && ADDR == OFS_CNT_A
        |=> RDATA == $past(count_val[CH_A])) else $error("count read wrong");

    cov_duty_end: cover property (act_set[CH_A] ##[1:200] act_clr[CH_A]);
    cov_full_duty: cover property (irq[CH_M] && output_value_bits[CH_A] && !act_clr[CH_A]);
    cov_stop: cover property (wr && ADDR == OFS_STOP ##1 channel_enable_status == 3'h0);
endmodule // pwm_group
`default_nettype wire

/* dv/pwm_load.sv */
// Load model on the PWM pins that measures period and high time
`timescale 1ns/100ps
`default_nettype none
module pwm_load (
    input wire logic clk,
    input wire logic pin_a,
    input wire logic pin_b,
    input wire logic period_irq,
    output var int len,
    output var int hi_a,
    output var int hi_b
);
    int cnt = 0;
    int acc_a = 0;
    int acc_b = 0;
    initial len = 0;
    initial hi_a = 0;
    initial hi_b = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Latch one window between master interrupts
    always @(posedge clk) begin
        if (period_irq) begin
            len <= cnt;
            hi_a <= acc_a;
            hi_b <= acc_b;
            cnt <= 1;
            acc_a <= int'(pin_a);
            acc_b <= int'(pin_b);
        end else begin
            cnt <= cnt + 1;
            acc_a <= acc_a + int'(pin_a);
            acc_b <= acc_b + int'(pin_b);
        end
    end
endmodule // pwm_load
`default_nettype wire

/* dv/pwm_group_tb.sv */
// Self-checking bench of the PWM group
`timescale 1ns/100ps
`default_nettype none
module pwm_group_tb
    import pwm_group_pkg::*;
;
    logic CLK = 0;
    logic RST = 1;
    logic [AW-1:0] ADDR = '0;
    logic [DW-1:0] WDATA = '0;
    logic WR_STROBE = 0;
    logic RD_STROBE = 0;
    logic [DW-1:0] RDATA;
    logic PWM_OUT_A, PWM_OUT_B, MASTER_OUT, TIMER_PIN_MODE, PERIOD_IRQ, DUTY_IRQ_A, DUTY_IRQ_B;
    int len, hi_a, hi_b, n_mismatch = 0, checks_done = 0, it, n;
    logic [31:0] seed = 32'hfed27585;
    logic [DW-1:0] p, da, db, c1, c2;
    logic [1:0] cks;
    logic pin;
    pwm_group DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR_STROBE(WR_STROBE),
        .RD_STROBE(RD_STROBE), .RDATA(RDATA), .PWM_OUT_A(PWM_OUT_A), .PWM_OUT_B(PWM_OUT_B),
        .MASTER_OUT(MASTER_OUT), .TIMER_PIN_MODE(TIMER_PIN_MODE), .PERIOD_IRQ(PERIOD_IRQ),
        .DUTY_IRQ_A(DUTY_IRQ_A), .DUTY_IRQ_B(DUTY_IRQ_B));
    pwm_load load (.clk(CLK), .pin_a(PWM_OUT_A), .pin_b(PWM_OUT_B), .period_irq(PERIOD_IRQ),
        .len(len), .hi_a(hi_a), .hi_b(hi_b));
    initial begin
        forever #2 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [DW-1:0] exp_hi(input logic [DW-1:0] d, input logic [DW-1:0] q);
        return ((d > q + 16'h1) ? q + 16'h1 : d) << n;
    endfunction
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STROBE <= 1'b1;
        @(posedge CLK);
        WR_STROBE <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD_STROBE <= 1'b1;
        @(posedge CLK);
        RD_STROBE <= 1'b0;
        #1;
        d = RDATA;
    endtask
    task automatic check_val(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string w);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string w);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %b exp %b", $time, w, got, exp);
        end
    endtask
    task automatic check_rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string w);
        logic [DW-1:0] d;
        rd(a, d);
        check_val(d, exp, w);
    endtask
    task automatic wait_irq(input int lim);
        int i;
        i = 0;
        do begin
            @(posedge CLK);
            #1;
            i++;
        end while (PERIOD_IRQ !== 1'b1 && i < lim);
        check_bit(PERIOD_IRQ, 1'b1, "period irq");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(30000 * 4);
        n_mismatch++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        wr(OFS_PERIOD, 16'h0005);
        wr(OFS_UNIT, 16'h0001);
        check_rd(OFS_PERIOD, 16'h0000, "ignored write");
        check_rd(OFS_ENABLE, 16'h0000, "stopped after enable");
        check_rd(OFS_CNT_M, RST_COUNT, "counter reset");
        check_rd(8'hfc, 16'h0000, "unmapped read");
        check_bit(TIMER_PIN_MODE, 1'b1, "timer pin mode");
        wr(OFS_PRESCALE, 16'h0010);
        wr(OFS_OUT_MODE, 16'h0006);
        wr(OFS_OUT_LVL, 16'h0000);
        wr(OFS_OUT_VAL, 16'h0002);
        repeat (2) @(posedge CLK);
        check_bit(PWM_OUT_A, 1'b1, "default level");
        wr(OFS_OUT_EN, 16'h0006);
        repeat (2) @(posedge CLK);
        check_bit(PWM_OUT_A, 1'b1, "level held when enabled");
        $display("test setup done");
        for (it = 0; it < 6; it++) begin
            seed = lfsr(seed);
            p = 16'(seed[3:0]) + 16'h1;
            da = 16'(seed[11:4]) % (p + 16'h3);
            db = 16'(seed[19:12]) % (p + 16'h3);
            if (it == 0) begin
                p = 16'h1;
                da = 16'h0;
                db = 16'h2;
            end
            if (it == 1) begin
                da = p + 16'h2;
                db = p + 16'h1;
            end
            n = it % 2;
            cks = (n == 1) ? CKS_CLK_B : CKS_CLK_A;
            wr(OFS_STOP, 16'h0007);
            wr(OFS_MODE0, {cks, 3'b001, 11'h001});
            check_rd(OFS_MODE0, {cks, 3'b000, 11'h001}, "master bit fixed");
            wr(OFS_MODE1, {cks, 14'h0000});
            wr(OFS_MODE2, {cks, 14'h0000});
            wr(OFS_PERIOD, p);
            wr(OFS_DUTY_A, da);
            wr(OFS_DUTY_B, db);
            wr(OFS_START, 16'h0007);
            wait_irq(6);
            check_rd(OFS_ENABLE, 16'h0007, "enable status");
            check_rd(OFS_START, 16'h0000, "start self clears");
            repeat (3) wait_irq(80);
            @(posedge CLK);
            #1;
            check_val(16'(len), (p + 16'h1) << n, "period");
            check_val(16'(hi_a), exp_hi(da, p), "duty a");
            check_val(16'(hi_b), exp_hi(db, p), "duty b");
            check_bit(MASTER_OUT, 1'b0, "master pin idle");
            $display("test %0d done p=%0d a=%0d b=%0d", it, p, da, db);
        end
        wr(OFS_STOP, 16'h0007);
        check_rd(OFS_ENABLE, 16'h0000, "stop clears enables");
        rd(OFS_CNT_M, c1);
        pin = PWM_OUT_B;
        rd(OFS_CNT_M, c2);
        check_val(c2, c1, "counter frozen");
        check_bit(c1 <= p, 1'b1, "counter in range");
        check_bit(PWM_OUT_B, pin, "pin held");
        wr(OFS_UNIT, 16'h0000);
        repeat (2) @(posedge CLK);
        #1;
        check_bit(TIMER_PIN_MODE, 1'b0, "port mode");
        check_bit(PWM_OUT_A, 1'b0, "pin cleared");
        check_rd(OFS_OUT_VAL, 16'h0000, "output bits cleared");
        check_rd(OFS_CNT_A, RST_COUNT, "counter reset");
        $display("test shutdown done");
        give_verdict;
    end
endmodule // pwm_group_tb
`default_nettype wire
